// [core/psm_top.sv]
// Purpose: Pulser-synchronized motion for one axis
// Assumes: Plain strobe register port, read data one cycle after the strobe
// Notes: Speed profile and interpolation arithmetic live outside this block
// Functional notes
// RULE1 - Codes 00/01/10 decode quadrature 1x/2x/4x, forward when A leads.
// RULE2 - Code 11 counts forward on A rising, backward on B rising.
// RULE3 - Direction-reverse bit set inverts the decoded count direction.
// RULE4 - Pulser input is accepted only while the enable bit is 1.
// RULE5 - Filter bit 0 rejects input pulses shorter than 150 ns.
// RULE6 - Status field reads 0101 while waiting for pulser input.
// RULE7 - Both inputs changing together set the simultaneous error; motion continues.
// RULE8 - Pulser buffer counter overflow sets the overflow error flag.
// RULE9 - Modes 01h, 51h, 52h, 53h, 54h, 55h select pulser motions.
// RULE10 - Modes 68h-6Dh, 78h-7Dh pace interpolation; direction ignores pulser reversal. The code leaves out 6Ah, 6Bh, 7Ah, 7Bh.
// RULE11 - Remaining-output set: stop waits until multiplied pulses are all out.
// RULE12 - Remaining-output clear: stop halts at once.
// RULE13 - Interpolation modes halt at once on stop regardless.
// RULE14 - Continuous mode feeds in decoded direction; reverse bit swaps it.
// RULE15 - Continuous mode blocks feed into an active end limit, resumes opposite.
// RULE16 - End-limit blocking raises no error and leaves error status alone.
// RULE17 - Host ends continuous operation with the stop command.
// RULE18 - Mode 51h loads target, counts down per pulse, stops at zero.
// RULE19 - Zero target outputs nothing and stops; direction from target sign.
// RULE20 - Mode 52h loads target minus counter 1; equal stops at once.
// RULE21 - Mode 53h is 52h using counter 2.
// RULE22 - Modes 54h/55h drive counter 1/2 toward zero; zero stops at once.
// RULE23 - Pulser counts scale by 1x-32x multiplier and n/2048 divider.
// RULE24 - After start, pulses and direction are output as pulser input arrives.
// RULE25 - Error flags stay set until the error status is read.
`timescale 1ns/1ps
module psm_top (
  input wire logic i_clk, // Core clock, 200 MHz
  input wire logic i_rstn, // Async reset, active low
  input wire logic [7:0] i_addr, // Register byte address
  input wire logic [31:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [31:0] o_rdata, // Read data, cycle after i_rd
  input wire logic i_pulser_phase_a_input, // Pulser phase A
  input wire logic i_pulser_phase_b_input, // Pulser phase B
  input wire logic i_end_limit_pos, // Plus end limit, high when on
  input wire logic i_end_limit_neg, // Minus end limit, high when on
  input wire logic i_interp_dir, // Direction from interpolation
  output logic o_pulse, // One-cycle output pulse
  output logic o_dir, // Output direction, high is plus
  output logic o_running, // Motion active
  output logic o_main_error_interrupt_flag // Error flag pending
);

  // ==========================================================
  // Decode front end
  logic [1:0] clean_ab;
  psm_pkg::psm_count_t dec;
  psm_pkg::psm_env2_t env2_q, env2_d;
  psm_pkg::psm_env5_t env5_q, env5_d;

  psm_filter psm_filter_inst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_bypass(env2_q.filt_dis),
    .i_raw({i_pulser_phase_b_input, i_pulser_phase_a_input}),
    .o_clean(clean_ab)
  );

  psm_decoder psm_decoder_inst (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_sel(env2_q.if_sel),
    .i_ab(clean_ab),
    .o_cnt(dec)
  );

  // ==========================================================
  // State
  psm_pkg::psm_state_t state_q, state_d;
  logic [7:0] mode_q, mode_d;
  logic [31:0] target_q, target_d, cnt1_q, cnt1_d, cnt2_q, cnt2_d;
  logic [31:0] rem_q, rem_d;
  logic [15:0] buf_q, buf_d;
  logic [10:0] acc_q, acc_d;
  logic [3:0] gap_q, gap_d;
  logic dir_q, dir_d, bufdir_q, bufdir_d;
  logic pulse_q, pulse_d, dout_q, dout_d;
  logic err_simul_q, err_simul_d, err_ovf_q, err_ovf_d;
  logic [31:0] rdata_q, rdata_d;

  logic is_cont, is_pos, is_interp;
  logic wr_cmd, start_cmd, stop_cmd, rd_err;
  logic [31:0] ref_diff, ref_mag;
  logic [5:0] mult_n;
  logic [16:0] prod, acc_sum, amt, sum17;
  logic accept, emit, lim_hit, ovf_evt, cnt_dir, new_dir, out_dir;
  logic [15:0] buf_v;
  logic [3:0] opst;

  assign is_cont = (mode_q == psm_pkg::MODE_CONT); // [RULE9]
  assign is_pos = mode_q inside {psm_pkg::MODE_INC, psm_pkg::MODE_ABS1, psm_pkg::MODE_ABS2,
                                 psm_pkg::MODE_ZR1, psm_pkg::MODE_ZR2};
  assign is_interp = mode_q inside {8'h68, 8'h69, 8'h6c, 8'h6d, 8'h78, 8'h79, 8'h7c, 8'h7d}; // [RULE10]
  assign wr_cmd = i_wr && (i_addr == psm_pkg::ADR_CMD);
  assign start_cmd = wr_cmd && i_wdata[psm_pkg::CMD_START];
  assign stop_cmd = wr_cmd && i_wdata[psm_pkg::CMD_STOP]; // [RULE17]
  assign rd_err = i_rd && (i_addr == psm_pkg::ADR_ERR);

  // ==========================================================
  // Start reference and scaling
  always_comb begin
    case (mode_q)
      psm_pkg::MODE_ABS1: ref_diff = target_q - cnt1_q; // [RULE20]
      psm_pkg::MODE_ABS2: ref_diff = target_q - cnt2_q; // [RULE21]
      psm_pkg::MODE_ZR1: ref_diff = 32'h0 - cnt1_q; // [RULE22]
      psm_pkg::MODE_ZR2: ref_diff = 32'h0 - cnt2_q; // [RULE22]
      default: ref_diff = target_q; // [RULE18]
    endcase
    ref_mag = ref_diff[31] ? (32'h0 - ref_diff) : ref_diff;
  end

  assign mult_n = {1'b0, env5_q.mult} + 6'h01;
  assign prod = 17'({11'h000, mult_n} * {5'h00, env5_q.div});
  assign acc_sum = {6'h00, acc_q} + prod;
  // Divider keeps its remainder so n/2048 holds on average [RULE23]
  assign amt = (env5_q.div == 12'h000) ? {11'h000, mult_n} : {11'h000, acc_sum[16:11]};
  assign cnt_dir = dec.up ^ env2_q.dir_rev; // [RULE3] [RULE14]
  assign new_dir = is_interp ? i_interp_dir : (is_cont ? cnt_dir : dir_q);
  assign accept = (state_q == psm_pkg::ST_RUN) && env2_q.in_en && (dec.up || dec.dn); // [RULE4]

  // ==========================================================
  // Motion and registers, next values
  always_comb begin
    state_d = state_q;
    mode_d = mode_q;
    target_d = target_q;
    cnt1_d = cnt1_q;
    cnt2_d = cnt2_q;
    rem_d = rem_q;
    acc_d = acc_q;
    gap_d = gap_q;
    dir_d = dir_q;
    bufdir_d = bufdir_q;
    env2_d = env2_q;
    env5_d = env5_q;
    pulse_d = 1'b0;
    dout_d = dout_q;
    emit = 1'b0;
    lim_hit = 1'b0;
    ovf_evt = 1'b0;
    out_dir = is_interp ? i_interp_dir : bufdir_q; // [RULE10]
    sum17 = 17'h00000;
    buf_v = buf_q;

    // Emission drains the buffer at the internal pulse rate
    if (state_q != psm_pkg::ST_IDLE) begin
      if (gap_q != 4'h0) begin
        gap_d = gap_q - 4'h1;
      end else if (buf_v != 16'h0000) begin
        lim_hit = is_cont && (bufdir_q ? i_end_limit_pos : i_end_limit_neg);
        if (lim_hit) begin
          buf_v = 16'h0000; // [RULE15] [RULE16]
        end else begin
          emit = 1'b1;
          pulse_d = 1'b1; // [RULE24]
          dout_d = out_dir;
          buf_v = buf_v - 16'h0001;
          gap_d = psm_pkg::PULSE_GAP_LAST;
          cnt1_d = out_dir ? cnt1_q + 32'h1 : cnt1_q - 32'h1;
          cnt2_d = out_dir ? cnt2_q + 32'h1 : cnt2_q - 32'h1;
          if (is_pos) begin
            rem_d = rem_q - 32'h1; // [RULE18]
          end
        end
      end
    end

    // New counts join the buffer; opposite counts cancel first
    if (accept) begin
      if (env5_q.div != 12'h000) begin
        acc_d = acc_sum[10:0];
      end
      if (buf_v == 16'h0000 || bufdir_q == new_dir) begin
        sum17 = {1'b0, buf_v} + amt;
        ovf_evt = sum17[16]; // [RULE8]
        buf_v = sum17[16] ? 16'hffff : sum17[15:0];
        bufdir_d = new_dir;
      end else if (amt > {1'b0, buf_v}) begin
        sum17 = amt - {1'b0, buf_v};
        buf_v = sum17[15:0];
        bufdir_d = new_dir;
      end else begin
        sum17 = {1'b0, buf_v} - amt;
        buf_v = sum17[15:0];
      end
    end
    buf_d = buf_v;

    // Positioning ends at zero and ignores further input
    if (is_pos && emit && rem_d == 32'h0) begin
      state_d = psm_pkg::ST_IDLE; // [RULE18]
      buf_d = 16'h0000;
      acc_d = 11'h000;
    end
    if (state_q == psm_pkg::ST_DRAIN && buf_d == 16'h0000) begin
      state_d = psm_pkg::ST_IDLE; // [RULE11]
    end

    if (stop_cmd && state_q != psm_pkg::ST_IDLE) begin
      if (env5_q.rem_out && !is_interp && buf_d != 16'h0000) begin
        state_d = psm_pkg::ST_DRAIN; // [RULE11]
      end else begin
        state_d = psm_pkg::ST_IDLE; // [RULE12] [RULE13]
        buf_d = 16'h0000;
      end
      acc_d = 11'h000;
    end else if (start_cmd && state_q == psm_pkg::ST_IDLE) begin
      buf_d = 16'h0000;
      acc_d = 11'h000;
      gap_d = 4'h0;
      if (is_pos) begin
        rem_d = ref_mag;
        dir_d = ~ref_diff[31]; // [RULE19]
        if (ref_mag != 32'h0) begin
          state_d = psm_pkg::ST_RUN;
        end
      end else if (is_cont || is_interp) begin
        state_d = psm_pkg::ST_RUN; // [RULE24]
      end
    end

    if (i_wr) begin
      unique case (i_addr)
        psm_pkg::ADR_MODE: mode_d = i_wdata[7:0];
        psm_pkg::ADR_TARGET: target_d = i_wdata;
        psm_pkg::ADR_CNT1: cnt1_d = i_wdata;
        psm_pkg::ADR_CNT2: cnt2_d = i_wdata;
        psm_pkg::ADR_ENV2: begin
          env2_d.if_sel = i_wdata[psm_pkg::ENV2_IFSEL_LO +: 2];
          env2_d.filt_dis = i_wdata[psm_pkg::ENV2_FILT_DIS];
          env2_d.dir_rev = i_wdata[psm_pkg::ENV2_DIR_REV];
          env2_d.in_en = i_wdata[psm_pkg::ENV2_IN_EN];
        end
        psm_pkg::ADR_ENV5: begin
          env5_d.mult = i_wdata[psm_pkg::ENV5_MULT_LO +: 5];
          env5_d.div = i_wdata[psm_pkg::ENV5_DIV_LO +: 12];
          env5_d.rem_out = i_wdata[psm_pkg::ENV5_REM_OUT];
        end
        default: ;
      endcase
    end

    // Set wins over the read that clears
    err_simul_d = (dec.simul && env2_q.in_en) || (err_simul_q && !rd_err); // [RULE7] [RULE25]
    err_ovf_d = ovf_evt || (err_ovf_q && !rd_err); // [RULE8] [RULE25]
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= psm_pkg::ST_IDLE;
      mode_q <= 8'h00;
      target_q <= 32'h0;
      cnt1_q <= 32'h0;
      cnt2_q <= 32'h0;
      rem_q <= 32'h0;
      buf_q <= 16'h0000;
      acc_q <= 11'h000;
      gap_q <= 4'h0;
      dir_q <= 1'b1;
      bufdir_q <= 1'b1;
      env2_q <= '0;
      env5_q <= '0;
      pulse_q <= 1'b0;
      dout_q <= 1'b1;
      err_simul_q <= 1'b0;
      err_ovf_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      target_q <= target_d;
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      rem_q <= rem_d;
      buf_q <= buf_d;
      acc_q <= acc_d;
      gap_q <= gap_d;
      dir_q <= dir_d;
      bufdir_q <= bufdir_d;
      env2_q <= env2_d;
      env5_q <= env5_d;
      pulse_q <= pulse_d;
      dout_q <= dout_d;
      err_simul_q <= err_simul_d;
      err_ovf_q <= err_ovf_d;
    end
  end

  // ==========================================================
  // Read port
  assign opst = (state_q == psm_pkg::ST_IDLE) ? psm_pkg::OPST_IDLE : psm_pkg::OPST_WAIT; // [RULE6]

  always_comb begin
    rdata_d = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        psm_pkg::ADR_MODE: rdata_d = {24'h0, mode_q};
        psm_pkg::ADR_TARGET: rdata_d = target_q;
        psm_pkg::ADR_CNT1: rdata_d = cnt1_q;
        psm_pkg::ADR_CNT2: rdata_d = cnt2_q;
        psm_pkg::ADR_REMAIN: rdata_d = rem_q;
        psm_pkg::ADR_STATUS: rdata_d = {23'h0, state_q == psm_pkg::ST_DRAIN, i_end_limit_neg,
                                        i_end_limit_pos, dout_q, o_running, opst};
        psm_pkg::ADR_ERR: rdata_d = {16'h0, err_ovf_q, err_simul_q, 14'h0};
        default: rdata_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_pulse = pulse_q;
  assign o_dir = dout_q;
  assign o_running = (state_q != psm_pkg::ST_IDLE);
  assign o_main_error_interrupt_flag = err_simul_q | err_ovf_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  a_idle_no_pulse: assert property ((state_q == psm_pkg::ST_IDLE) [*2] |=> !pulse_q) // [RULE18]
    else $error("pulse while idle");
  a_pulse_spacing: assert property (pulse_q |=> !pulse_q [*3]) // [RULE24]
    else $error("pulses too close");
  a_simul_set: assert property (dec.simul && env2_q.in_en |=> err_simul_q && o_main_error_interrupt_flag) // [RULE7]
    else $error("simultaneous change not flagged");
  // A stop or a finished move in the same cycle may legally empty the buffer
  a_ovf_set: assert property (ovf_evt |=> err_ovf_q && (buf_q == 16'hffff || state_q == psm_pkg::ST_IDLE)) // [RULE8]
    else $error("overflow not flagged");
  a_err_hold: assert property (err_simul_q && !rd_err |=> err_simul_q) // [RULE25]
    else $error("error flag lost");
  a_zero_start: assert property (start_cmd && state_q == psm_pkg::ST_IDLE && is_pos && ref_mag == 32'h0
                                 |=> state_q == psm_pkg::ST_IDLE [*3]) // [RULE19]
    else $error("zero move started");
  a_stop_now: assert property (stop_cmd && state_q != psm_pkg::ST_IDLE && (!env5_q.rem_out || is_interp)
                               |=> state_q == psm_pkg::ST_IDLE && buf_q == 16'h0000) // [RULE12]
    else $error("stop not immediate");
  a_wait_code: assert property (state_q == psm_pkg::ST_RUN |-> opst == psm_pkg::OPST_WAIT) // [RULE6]
    else $error("wrong operation state code");
  a_limit_block: assert property (lim_hit && !accept && !rd_err
                                  |=> !pulse_q && buf_q == 16'h0000 && $stable(err_ovf_q)) // [RULE15]
    else $error("pulse into active limit");
  a_input_off: assert property (!env2_q.in_en |-> !accept) // [RULE4]
    else $error("input taken while disabled");
  a_drain_end: assert property (state_q == psm_pkg::ST_DRAIN && buf_q == 16'h0000
                                |=> state_q == psm_pkg::ST_IDLE) // [RULE11]
    else $error("drain did not finish");

endmodule

// [common/psm_pkg.sv]
// Purpose: Shared constants and types of the pulser-synchronized motion block
// Assumes: 200 MHz core clock, 32-bit register words on a plain strobe port
// Notes: Byte offsets are word aligned; bits above a field read as zero
package psm_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FILT_NS = 150;
  localparam int unsigned FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam logic [4:0] FILT_LAST = 5'(FILT_CYC - 1);
  // Internal output pulse spacing; stands in for the speed generator
  localparam logic [3:0] PULSE_GAP_LAST = 4'h3;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] ADR_CMD = 8'h00;
  localparam logic [7:0] ADR_MODE = 8'h04;
  localparam logic [7:0] ADR_ENV2 = 8'h08;
  localparam logic [7:0] ADR_ENV5 = 8'h0c;
  localparam logic [7:0] ADR_TARGET = 8'h10;
  localparam logic [7:0] ADR_CNT1 = 8'h14;
  localparam logic [7:0] ADR_CNT2 = 8'h18;
  localparam logic [7:0] ADR_REMAIN = 8'h1c;
  localparam logic [7:0] ADR_STATUS = 8'h20;
  localparam logic [7:0] ADR_ERR = 8'h24;

  // ==========================================================
  // Field positions
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int ENV2_IFSEL_LO = 8;
  localparam int ENV2_FILT_DIS = 14;
  localparam int ENV2_DIR_REV = 16;
  localparam int ENV2_IN_EN = 17;
  localparam int ENV5_MULT_LO = 0;
  localparam int ENV5_DIV_LO = 5;
  localparam int ENV5_REM_OUT = 17;
  localparam int ERR_SIMUL = 14;
  localparam int ERR_OVF = 15;

  // ==========================================================
  // Interface select, modes, status codes
  localparam logic [1:0] IF_X1 = 2'h0;
  localparam logic [1:0] IF_X2 = 2'h1;
  localparam logic [1:0] IF_X4 = 2'h2;
  localparam logic [1:0] IF_UPDN = 2'h3;
  localparam logic [7:0] MODE_CONT = 8'h01;
  localparam logic [7:0] MODE_INC = 8'h51;
  localparam logic [7:0] MODE_ABS1 = 8'h52;
  localparam logic [7:0] MODE_ABS2 = 8'h53;
  localparam logic [7:0] MODE_ZR1 = 8'h54;
  localparam logic [7:0] MODE_ZR2 = 8'h55;
  localparam logic [3:0] OPST_IDLE = 4'h0;
  localparam logic [3:0] OPST_WAIT = 4'h5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DRAIN = 3'b100
  } psm_state_t;

  typedef struct packed {
    logic in_en;
    logic dir_rev;
    logic filt_dis;
    logic [1:0] if_sel;
  } psm_env2_t;

  typedef struct packed {
    logic rem_out;
    logic [11:0] div;
    logic [4:0] mult;
  } psm_env5_t;

  typedef struct packed {
    logic up;
    logic dn;
    logic simul;
  } psm_count_t;

endpackage

// [core/psm_filter.sv]
// Purpose: Glitch filter for the two pulser phase inputs
// Assumes: Inputs already synchronous to i_clk
// Notes: A level is adopted only after it has stood for the full filter time
`timescale 1ns/1ps
module psm_filter (
  input wire logic i_clk, // Core clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic i_bypass, // High passes inputs unfiltered
  input wire logic [1:0] i_raw, // Phase B, phase A
  output logic [1:0] o_clean // Filtered phases
);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bit
      logic [4:0] cnt_q, cnt_d;
      logic out_q, out_d;

      always_comb begin
        cnt_d = cnt_q;
        out_d = out_q;
        if (i_bypass) begin
          out_d = i_raw[g];
          cnt_d = 5'h00;
        end else if (i_raw[g] == out_q) begin
          cnt_d = 5'h00;
        end else if (cnt_q == psm_pkg::FILT_LAST) begin
          out_d = i_raw[g]; // [RULE5]
          cnt_d = 5'h00;
        end else begin
          cnt_d = cnt_q + 5'h01;
        end
      end

      always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
          cnt_q <= 5'h00;
          out_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          out_q <= out_d;
        end
      end

      assign o_clean[g] = out_q;
    end
  endgenerate

endmodule

// [core/psm_decoder.sv]
// Purpose: Quadrature and up/down decoding of the filtered pulser phases
// Assumes: Phases come from psm_filter
// Notes: Counts are one-cycle pulses; up means phase A leads, or in up/down mode a rising edge on A
`timescale 1ns/1ps
module psm_decoder (
  input wire logic i_clk, // Core clock
  input wire logic i_rstn, // Async reset, active low
  input wire logic [1:0] i_sel, // Interface select
  input wire logic [1:0] i_ab, // Phase B, phase A
  output psm_pkg::psm_count_t o_cnt // Registered count pulses
);

  logic [1:0] prev_q;
  psm_pkg::psm_count_t cnt_q, cnt_d;
  logic a, b, a_chg, b_chg;

  assign a = i_ab[0];
  assign b = i_ab[1];
  assign a_chg = a ^ prev_q[0];
  assign b_chg = b ^ prev_q[1];

  always_comb begin
    cnt_d = '0;
    cnt_d.simul = a_chg & b_chg; // [RULE7]
    if (!(a_chg & b_chg)) begin
      unique case (i_sel)
        psm_pkg::IF_X1: begin
          cnt_d.up = a_chg & a & ~b; // [RULE1]
          cnt_d.dn = a_chg & ~a & ~b;
        end
        psm_pkg::IF_X2: begin
          cnt_d.up = a_chg & (a ^ b); // [RULE1]
          cnt_d.dn = a_chg & ~(a ^ b);
        end
        psm_pkg::IF_X4: begin
          cnt_d.up = (a_chg & (a ^ b)) | (b_chg & ~(a ^ b)); // [RULE1]
          cnt_d.dn = (a_chg & ~(a ^ b)) | (b_chg & (a ^ b));
        end
        psm_pkg::IF_UPDN: begin
          cnt_d.up = a_chg & a; // [RULE2]
          cnt_d.dn = b_chg & b;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prev_q <= 2'h0;
      cnt_q <= '0;
    end else begin
      prev_q <= i_ab;
      cnt_q <= cnt_d;
    end
  end

  assign o_cnt = cnt_q;

endmodule

// [verif/psm_pulser_model.sv]
// Purpose: Manual pulse generator driving the two pulser phases
// Assumes: quad and updn hold each level longer than the 150 ns input filter; put holds for any given count
// Notes: Phases rest low between moves; no free-running output
`timescale 1ns/1ps
module psm_pulser_model (
  input wire logic i_clk, // Core clock
  output logic o_a, // Phase A
  output logic o_b // Phase B
);
  localparam int HOLD = 40;
  // Forward quadrature as {b, a}: A leads B
  localparam logic [1:0] FWD [4] = '{2'h1, 2'h3, 2'h2, 2'h0};
  initial begin
    o_a = 1'b0;
    o_b = 1'b0;
  end
  // ==========================================
  // Phase steps
  task automatic put(input logic [1:0] s, input int h);
    @(posedge i_clk);
    o_a <= s[0];
    o_b <= s[1];
    repeat (h) @(posedge i_clk);
  endtask
  task automatic quad(input logic fwd, input int n);
    logic [1:0] s;
    for (int k = 0; k < 4 * n; k++) begin
      s = FWD[k % 4];
      put(fwd ? s : {s[0], s[1]}, HOLD);
    end
  endtask
  // Up on A, down on B; one full pulse each
  task automatic updn(input logic up, input int n);
    repeat (n) begin
      put(up ? 2'h1 : 2'h2, HOLD);
      put(2'h0, HOLD);
    end
  endtask
endmodule

// [verif/psm_top_tb_top.sv]
// Purpose: Self-checking bench for pulser-synchronized motion
// Assumes: Pulser model holds levels past the filter time, except in the glitch and overflow tests
// Notes: Pulse counts are compared once the output has gone quiet
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); \
  end \
end
module psm_top_tb_top;
  logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, lim_p = 1'b0, lim_n = 1'b0, idir = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic pa, pb, pulse, dir, running, err;
  int n_errors = 0, checks = 0, npulse = 0, n0 = 0, cyc = 0;
  // Moves of three pulses each: mode, target, counter 1, counter 2, direction
  logic [7:0] pmode [5] = '{8'h51, 8'h52, 8'h53, 8'h54, 8'h55};
  logic [31:0] ptgt [5] = '{32'h3, 32'h2, 32'h4, 32'h0, 32'h0};
  logic [31:0] pc1 [5] = '{32'h0, 32'h5, 32'h0, 32'h3, 32'h0};
  logic [31:0] pc2 [5] = '{32'h0, 32'h0, 32'h1, 32'h0, 32'hfffffffd};
  logic pdir [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
  always #2.5 clk = ~clk;
  always @(posedge clk) npulse += pulse;
  // Runaway guard, well above the cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      summarize();
    end
  end
  psm_top psm_top_inst (.i_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_pulser_phase_a_input(pa), .i_pulser_phase_b_input(pb), .i_end_limit_pos(lim_p),
    .i_end_limit_neg(lim_n), .i_interp_dir(idir), .o_pulse(pulse), .o_dir(dir), .o_running(running),
    .o_main_error_interrupt_flag(err));
  psm_pulser_model psm_pulser_model_inst (.i_clk(clk), .o_a(pa), .o_b(pb));
  // ==========================================
  // Access and check tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask
  // Stop first so the start always meets an idle axis
  task automatic cfg(input logic [1:0] s, input logic f, r, e, input logic [7:0] m);
    wreg(psm_pkg::ADR_CMD, 32'h2);
    wreg(psm_pkg::ADR_ENV2, 32'({e, r, 1'b0, f, 4'h0, s, 8'h00}));
    wreg(psm_pkg::ADR_MODE, 32'(m));
    wreg(psm_pkg::ADR_CMD, 32'h1);
    n0 = npulse;
  endtask
  task automatic chk_p(input int n, input logic d, input string nm);
    repeat (20) @(posedge clk);
    #1;
    `CHK(nm, n, npulse - n0)
    if (n > 0) `CHK(nm, d, dir)
    n0 = npulse;
  endtask
  // ==========================================
  // Tests
  initial begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rreg(psm_pkg::ADR_STATUS);
    `CHK("opst", psm_pkg::OPST_IDLE, rv[3:0])
    cfg(psm_pkg::IF_UPDN, 1'b1, 1'b0, 1'b1, psm_pkg::MODE_CONT);
    rreg(psm_pkg::ADR_STATUS);
    `CHK("opst", psm_pkg::OPST_WAIT, rv[3:0])
    psm_pulser_model_inst.updn(1'b1, 2);
    chk_p(2, 1'b1, "up");
    psm_pulser_model_inst.updn(1'b0, 1);
    chk_p(1, 1'b0, "down");
    cfg(psm_pkg::IF_UPDN, 1'b1, 1'b1, 1'b1, psm_pkg::MODE_CONT);
    psm_pulser_model_inst.updn(1'b1, 1);
    chk_p(1, 1'b0, "rev");
    $display("test updown done");
    for (int s = 0; s < 3; s++) begin
      cfg(2'(s), 1'b1, 1'b0, 1'b1, psm_pkg::MODE_CONT);
      psm_pulser_model_inst.quad(1'b1, 2);
      chk_p(2 << s, 1'b1, "qfwd");
      psm_pulser_model_inst.quad(1'b0, 1);
      chk_p(1 << s, 1'b0, "qback");
    end
    cfg(psm_pkg::IF_X4, 1'b1, 1'b0, 1'b0, psm_pkg::MODE_CONT);
    psm_pulser_model_inst.quad(1'b1, 1);
    chk_p(0, 1'b0, "off");
    $display("test decode done");
    cfg(psm_pkg::IF_X4, 1'b1, 1'b0, 1'b1, psm_pkg::MODE_CONT);
    psm_pulser_model_inst.put(2'h3, 40);
    psm_pulser_model_inst.put(2'h0, 40);
    `CHK("flag", 1'b1, err)
    `CHK("run", 1'b1, running)
    rreg(psm_pkg::ADR_ERR);
    `CHK("simul", 32'h4000, rv)
    rreg(psm_pkg::ADR_ERR);
    `CHK("clear", 32'h0, rv)
    cfg(psm_pkg::IF_UPDN, 1'b0, 1'b0, 1'b1, psm_pkg::MODE_CONT);
    psm_pulser_model_inst.put(2'h1, 10);
    psm_pulser_model_inst.put(2'h0, 40);
    chk_p(0, 1'b0, "glitch");
    psm_pulser_model_inst.updn(1'b1, 1);
    chk_p(1, 1'b1, "long");
    $display("test errors done");
    @(posedge clk);
    lim_p <= 1'b1;
    psm_pulser_model_inst.updn(1'b1, 1);
    chk_p(0, 1'b1, "limit");
    psm_pulser_model_inst.updn(1'b0, 1);
    chk_p(1, 1'b0, "away");
    `CHK("flag", 1'b0, err)
    rreg(psm_pkg::ADR_ERR);
    `CHK("lim_err", 32'h0, rv)
    @(posedge clk);
    lim_p <= 1'b0;
    idir <= 1'b1;
    // Pass 2 runs interpolation with reversal set: direction must follow idir
    for (int r = 2; r >= 0; r--) begin
      wreg(psm_pkg::ADR_ENV5, 32'({r != 0, 17'h2}));
      cfg(psm_pkg::IF_UPDN, 1'b1, r == 2, 1'b1, (r == 2) ? 8'h68 : psm_pkg::MODE_CONT);
      fork
        psm_pulser_model_inst.updn(1'b1, 1);
      join_none
      @(posedge pulse);
      wreg(psm_pkg::ADR_CMD, 32'h2);
      wait fork;
      chk_p(r == 1 ? 3 : 1, 1'b1, "stop");
      `CHK("run", 1'b0, running)
    end
    wreg(psm_pkg::ADR_ENV5, 32'h8000);
    cfg(psm_pkg::IF_UPDN, 1'b1, 1'b0, 1'b1, psm_pkg::MODE_CONT);
    psm_pulser_model_inst.updn(1'b1, 4);
    chk_p(2, 1'b1, "div");
    // Fastest 32x input outruns the output and fills the buffer
    wreg(psm_pkg::ADR_ENV5, 32'h1f);
    cfg(psm_pkg::IF_UPDN, 1'b1, 1'b0, 1'b1, psm_pkg::MODE_CONT);
    repeat (2200) begin
      psm_pulser_model_inst.put(2'h1, 1);
      psm_pulser_model_inst.put(2'h0, 1);
    end
    wreg(psm_pkg::ADR_CMD, 32'h2);
    `CHK("ovf_flag", 1'b1, err)
    rreg(psm_pkg::ADR_ERR);
    `CHK("ovf", 32'h8000, rv)
    wreg(psm_pkg::ADR_ENV5, 32'h0);
    $display("test stop done");
    for (int i = 0; i < 5; i++) begin
      wreg(psm_pkg::ADR_TARGET, ptgt[i]);
      wreg(psm_pkg::ADR_CNT1, pc1[i]);
      wreg(psm_pkg::ADR_CNT2, pc2[i]);
      cfg(psm_pkg::IF_UPDN, 1'b1, 1'b0, 1'b1, pmode[i]);
      psm_pulser_model_inst.updn(1'b1, 5);
      chk_p(3, pdir[i], "move");
      `CHK("done", 1'b0, running)
    end
    wreg(psm_pkg::ADR_TARGET, 32'h0);
    cfg(psm_pkg::IF_UPDN, 1'b1, 1'b0, 1'b1, psm_pkg::MODE_INC);
    psm_pulser_model_inst.updn(1'b1, 2);
    chk_p(0, 1'b1, "zero");
    `CHK("zrun", 1'b0, running)
    $display("test moves done");
    summarize();
  end
endmodule
